/* File: rtl/chaq_pkg.sv */
/*
 * Shared constants and carrier types for the channel assessment and
 * link quality block.
 * Assumes a 50 MHz digital clock and a register front end that hands
 * over decoded single-byte register accesses.
 */
package chaq_pkg;

	// -----------------------------------------------------------------
	// Register map
	// -----------------------------------------------------------------
	localparam logic [5:0] ADDR_STATUS = 6'h01;
	localparam logic [5:0] ADDR_CONTROL = 6'h08;
	localparam logic [5:0] ADDR_THRESH = 6'h09;

	localparam int BIT_DONE = 7;
	localparam int BIT_IDLE = 6;
	localparam int BIT_TRIGGER = 7;
	localparam int METHOD_HI = 6;
	localparam int METHOD_LO = 5;
	localparam int STEP_HI = 4;

	localparam logic [7:0] THRESH_RESET = 8'hC7;
	localparam logic [1:0] METHOD_RESET = 2'h0;
	localparam logic [7:0] LQ_RESET = 8'h00;

	// -----------------------------------------------------------------
	// Timing
	// -----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int MEAS_TIME_NS = 140000;
	localparam int MEAS_CYCLES = MEAS_TIME_NS / CLK_PERIOD_NS;

	// -----------------------------------------------------------------
	// Link quality
	// -----------------------------------------------------------------
	localparam logic [6:0] MIN_LQ_LEN = 7'h02;
	localparam int LQ_SHIFT = 2;

	typedef enum logic [1:0] {
		CHAQ_OR = 2'b00,
		CHAQ_ENERGY = 2'b01,
		CHAQ_CARRIER = 2'b10,
		CHAQ_AND = 2'b11
	} chaq_method_t;

	typedef enum logic [0:0] {
		CHAQ_IDLE = 1'b0,
		CHAQ_RUN = 1'b1
	} chaq_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [5:0] addr;
		logic [7:0] wdata;
	} chaq_reg_req_t;

	typedef struct packed {
		logic wr;
		logic [6:0] addr;
		logic [7:0] data;
	} chaq_fb_wr_t;

endpackage

/* File: rtl/chaq_top.sv */
/*
 * Channel assessment control/status registers and link quality append.
 * Assumes the register front end delivers one-cycle wr/rd strobes on clk,
 * and the receiver baseband drives its indications on clk as well.
 */
`timescale 1ns/10ps

module chaq_top #(
	parameter int MEAS_CYCLES = chaq_pkg::MEAS_CYCLES,
	parameter logic signed [7:0] FLOOR_BASE = -8'sd90
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire chaq_pkg::chaq_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	input wire logic rx_basic,
	input wire logic signed [7:0] rx_power,
	input wire logic carrier_seen,
	input wire logic corr_valid,
	input wire logic [7:0] corr_value,
	input wire logic frame_end_event,
	input wire logic [6:0] frame_len,
	output chaq_pkg::chaq_fb_wr_t fb_wr,
	output logic measure_done_event
);

	// -----------------------------------------------------------------
	// Register decode
	// -----------------------------------------------------------------
	logic wr_ctl, wr_thr, rd_any, accept;
	logic [7:0] thr_r, thr_nxt, rdata_r, rdata_nxt;
	logic [1:0] method_r, method_nxt;

	assign wr_ctl = reg_req.wr && reg_req.addr == chaq_pkg::ADDR_CONTROL;
	assign wr_thr = reg_req.wr && reg_req.addr == chaq_pkg::ADDR_THRESH;
	assign rd_any = reg_req.rd;

	// -----------------------------------------------------------------
	// Assessment engine
	// -----------------------------------------------------------------
	chaq_pkg::chaq_state_t state_r, state_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic done_r, done_nxt, idle_r, idle_nxt, evt_r, evt_nxt;
	logic ed_r, ed_nxt, cs_r, cs_nxt, busy, ed_now;
	logic signed [8:0] limit;

	// A request while a check runs is not accepted, so each accepted
	// request yields exactly one completion event.
	assign accept = wr_ctl && reg_req.wdata[chaq_pkg::BIT_TRIGGER]
		&& state_r == chaq_pkg::CHAQ_IDLE;

	assign limit = 9'(FLOOR_BASE) + 9'({thr_r[chaq_pkg::STEP_HI:0], 1'b0});
	assign ed_now = 9'(rx_power) > limit;

	always_comb begin
		case (chaq_pkg::chaq_method_t'(method_r))
			chaq_pkg::CHAQ_OR: busy = ed_r | cs_r;
			chaq_pkg::CHAQ_ENERGY: busy = ed_r;
			chaq_pkg::CHAQ_CARRIER: busy = cs_r;
			chaq_pkg::CHAQ_AND: busy = ed_r & cs_r;
			default: busy = 1'b1;
		endcase
	end

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		done_nxt = done_r;
		idle_nxt = idle_r;
		ed_nxt = ed_r;
		cs_nxt = cs_r;
		evt_nxt = 1'b0;
		case (state_r)
			chaq_pkg::CHAQ_IDLE: begin
				if (accept) begin
					idle_nxt = 1'b0;
					ed_nxt = 1'b0;
					cs_nxt = 1'b0;
					cnt_nxt = 16'h0000;
					if (rx_basic) begin
						done_nxt = 1'b0;
						state_nxt = chaq_pkg::CHAQ_RUN;
					end else begin
						done_nxt = 1'b1;
						evt_nxt = 1'b1;
					end
				end
			end
			chaq_pkg::CHAQ_RUN: begin
				ed_nxt = ed_r | ed_now;
				cs_nxt = cs_r | carrier_seen;
				cnt_nxt = cnt_r + 16'h0001;
				if (cnt_r == 16'(MEAS_CYCLES - 1)) begin
					state_nxt = chaq_pkg::CHAQ_IDLE;
					done_nxt = 1'b1;
					idle_nxt = ~busy;
					evt_nxt = 1'b1;
				end
			end
			default: state_nxt = chaq_pkg::CHAQ_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= chaq_pkg::CHAQ_IDLE;
			cnt_r <= 16'h0000;
			done_r <= 1'b0;
			idle_r <= 1'b0;
			ed_r <= 1'b0;
			cs_r <= 1'b0;
			evt_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
			idle_r <= idle_nxt;
			ed_r <= ed_nxt;
			cs_r <= cs_nxt;
			evt_r <= evt_nxt;
		end
	end

	assign measure_done_event = evt_r;

	// -----------------------------------------------------------------
	// Register file
	// -----------------------------------------------------------------
	always_comb begin
		thr_nxt = wr_thr ? reg_req.wdata : thr_r;
		method_nxt = method_r;
		if (wr_ctl)
			method_nxt = reg_req.wdata[chaq_pkg::METHOD_HI:chaq_pkg::METHOD_LO];
		rdata_nxt = rdata_r;
		if (rd_any) begin
			case (reg_req.addr)
				// Flag bits are status only; writes to 0x01 fall through.
				chaq_pkg::ADDR_STATUS: rdata_nxt = {done_r, idle_r, 6'h00};
				// Trigger is never stored, so it reads as zero.
				chaq_pkg::ADDR_CONTROL: rdata_nxt = {1'b0, method_r, 5'h00};
				chaq_pkg::ADDR_THRESH: rdata_nxt = thr_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			thr_r <= chaq_pkg::THRESH_RESET;
			method_r <= chaq_pkg::METHOD_RESET;
			rdata_r <= 8'h00;
		end else begin
			thr_r <= thr_nxt;
			method_r <= method_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;

	// -----------------------------------------------------------------
	// Link quality
	// -----------------------------------------------------------------
	logic [7:0] lq_r, lq_nxt;
	chaq_pkg::chaq_fb_wr_t fb_r, fb_nxt;

	// A running average over symbol correlations; cheap and stays in
	// 0..255 without a divider, at the cost of weighting late symbols.
	always_comb begin
		lq_nxt = lq_r;
		fb_nxt = '0;
		if (corr_valid)
			lq_nxt = lq_r - (lq_r >> chaq_pkg::LQ_SHIFT)
				+ (corr_value >> chaq_pkg::LQ_SHIFT);
		if (frame_end_event) begin
			fb_nxt.wr = 1'b1;
			fb_nxt.addr = frame_len;
			fb_nxt.data = (frame_len >= chaq_pkg::MIN_LQ_LEN) ? lq_r
				: 8'h00;
			lq_nxt = chaq_pkg::LQ_RESET;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lq_r <= chaq_pkg::LQ_RESET;
			fb_r <= '0;
		end else begin
			lq_r <= lq_nxt;
			fb_r <= fb_nxt;
		end
	end

	assign fb_wr = fb_r;

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	localparam int MEAS_LEN = MEAS_CYCLES;

	sequence s_start_meas;
		accept && rx_basic;
	endsequence

	sequence s_finish;
		evt_r && done_r;
	endsequence

	property p_clear_on_req;
		@(posedge clk) disable iff (!rst_b)
		s_start_meas |=> !done_r && !idle_r;
	endproperty
	a_clear_on_req: assert property (p_clear_on_req)
		else $error("flags not cleared on request");

	property p_no_meas;
		@(posedge clk) disable iff (!rst_b)
		accept && !rx_basic |=> s_finish ##1 !evt_r;
	endproperty
	a_no_meas: assert property (p_no_meas)
		else $error("request outside receive did not complete at once");

	property p_meas_len;
		@(posedge clk) disable iff (!rst_b)
		state_r == chaq_pkg::CHAQ_RUN && state_nxt == chaq_pkg::CHAQ_IDLE
			|-> cnt_r == 16'(MEAS_LEN - 1) ##1 s_finish;
	endproperty
	a_meas_len: assert property (p_meas_len)
		else $error("measurement length wrong");

	property p_once;
		@(posedge clk) disable iff (!rst_b)
		evt_r |-> (!$past(done_r) || $past(accept)) ##1 !evt_r;
	endproperty
	a_once: assert property (p_once)
		else $error("completion event repeated");

	property p_result;
		@(posedge clk) disable iff (!rst_b)
		state_r == chaq_pkg::CHAQ_RUN && state_nxt == chaq_pkg::CHAQ_IDLE
			|=> idle_r == !$past(busy);
	endproperty
	a_result: assert property (p_result)
		else $error("idle flag does not match method");

	property p_status_read;
		@(posedge clk) disable iff (!rst_b)
		rd_any && reg_req.addr == chaq_pkg::ADDR_STATUS
			|=> reg_rdata[7:6] == $past({done_r, idle_r});
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("status read mismatch");

	property p_trig_zero;
		@(posedge clk) disable iff (!rst_b)
		rd_any && reg_req.addr == chaq_pkg::ADDR_CONTROL
			|=> !reg_rdata[chaq_pkg::BIT_TRIGGER];
	endproperty
	a_trig_zero: assert property (p_trig_zero)
		else $error("trigger bit read back as one");

	property p_thr_write;
		@(posedge clk) disable iff (!rst_b)
		wr_thr |=> thr_r == $past(reg_req.wdata);
	endproperty
	a_thr_write: assert property (p_thr_write)
		else $error("threshold write lost");

	property p_lq_append;
		@(posedge clk) disable iff (!rst_b)
		frame_end_event |=> fb_wr.wr && fb_wr.addr == $past(frame_len)
			&& fb_wr.data == ($past(frame_len) >= chaq_pkg::MIN_LQ_LEN
			? $past(lq_r) : 8'h00) ##1 !fb_wr.wr;
	endproperty
	a_lq_append: assert property (p_lq_append)
		else $error("quality byte not appended");

endmodule

/* File: testbench/channel_assess_and_lqi_bench.sv */
/*
 * Self-checking bench for the channel assessment and quality block.
 * Assumes the host model and a 50 MHz clock with active low reset.
 */
`timescale 1ns/10ps
module channel_assess_and_lqi_bench;
	localparam int MC = 8;
	logic clk, rst_b, rx_basic, carrier_seen, corr_valid, fe, busy;
	logic signed [7:0] rx_power;
	logic [7:0] corr_value, reg_rdata, rd, v;
	logic [6:0] frame_len;
	logic measure_done_event;
	chaq_pkg::chaq_reg_req_t reg_req;
	chaq_pkg::chaq_fb_wr_t fb_wr;
	int err_count, tests_run, cyc, t0, evc, evn, q, n, c;

	chaq_top #(.MEAS_CYCLES(MC)) dut_u (.clk(clk), .rst_b(rst_b),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .rx_basic(rx_basic),
		.rx_power(rx_power), .carrier_seen(carrier_seen),
		.corr_valid(corr_valid), .corr_value(corr_value),
		.frame_end_event(fe), .frame_len(frame_len), .fb_wr(fb_wr),
		.measure_done_event(measure_done_event));
	chaq_host_model host_u (.clk(clk), .reg_rdata(reg_rdata),
		.reg_req(reg_req));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (measure_done_event === 1'b1) begin
			evc <= cyc;
			evn <= evn + 1;
		end
	end

	task automatic check(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// A second request is sent mid-run so a restarting engine shows up.
	task automatic assess(input logic [1:0] m, input logic basic,
		input int lat);
		@(posedge clk);
		rx_basic <= basic;
		n = evn;
		host_u.wr_reg(chaq_pkg::ADDR_CONTROL, {1'b1, m, 5'h00});
		t0 = cyc;
		if (basic) begin
			host_u.rd_reg(chaq_pkg::ADDR_STATUS, rd);
			check("flags in run", 8'h00, rd & 8'hC0);
			host_u.wr_reg(chaq_pkg::ADDR_CONTROL, {1'b1, m, 5'h00});
		end
		repeat (MC + 4) @(posedge clk);
		check("event count", 8'h01, 8'(evn - n));
		check("latency", 8'(lat), 8'(evc - t0));
		host_u.rd_reg(chaq_pkg::ADDR_STATUS, rd);
		check("status", {1'b1, basic & ~busy, 6'h00}, rd & 8'hC0);
		host_u.rd_reg(chaq_pkg::ADDR_CONTROL, rd);
		check("control", {1'b0, m, 5'h00}, rd);
	endtask

	initial begin
		#200000;
		err_count++;
		tally_and_finish();
	end

	// -----------------------------------------------------------------
	// Tests
	// -----------------------------------------------------------------
	initial begin
		rst_b = 1'b0;
		rx_basic = 1'b0;
		rx_power = '0;
		carrier_seen = 1'b0;
		corr_valid = 1'b0;
		corr_value = '0;
		fe = 1'b0;
		frame_len = '0;
		void'($urandom(32'hB7FC));
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		host_u.rd_reg(chaq_pkg::ADDR_THRESH, rd);
		check("threshold reset", 8'hC7, rd);
		host_u.rd_reg(6'h3F, rd);
		check("unmapped", 8'h00, rd);
		host_u.wr_reg(chaq_pkg::ADDR_STATUS, 8'hC0);
		host_u.rd_reg(chaq_pkg::ADDR_STATUS, rd);
		check("status write", 8'h00, rd & 8'hC0);
		$display("register test done");
		for (int m = 0; m < 4; m++) begin
			for (int k = 0; k < 4; k++) begin
				v = 8'($urandom_range(255));
				host_u.wr_reg(chaq_pkg::ADDR_THRESH, v);
				host_u.rd_reg(chaq_pkg::ADDR_THRESH, rd);
				check("threshold", v, rd);
				rx_power <= 8'(-90 + 2 * int'(v[4:0]) + k[0]);
				carrier_seen <= k[1];
				busy = (m == 0) ? (k != 0) : (m == 3) ? (k == 3) : k[m - 1];
				assess(2'(m), 1'b1, MC + 1);
			end
		end
		assess(2'h1, 1'b0, 1);
		$display("assessment test done");
		// Short frames come first so the zero quality case is always seen.
		for (int f = 0; f < 8; f++) begin
			q = 0;
			repeat ($urandom_range(12)) begin
				@(posedge clk);
				c = $urandom_range(255);
				corr_value <= 8'(c);
				corr_valid <= 1'b1;
				q = q - q / 4 + c / 4;
			end
			@(posedge clk);
			corr_valid <= 1'b0;
			n = (f < 2) ? f : $urandom_range(127, 2);
			frame_len <= 7'(n);
			fe <= 1'b1;
			@(posedge clk);
			fe <= 1'b0;
			#1;
			check("quality strobe", 8'h01, {7'h00, fb_wr.wr});
			check("quality addr", 8'(n), {1'b0, fb_wr.addr});
			check("quality", (n < 2) ? 8'h00 : 8'(q), fb_wr.data);
		end
		$display("quality test done");
		tally_and_finish();
	end
endmodule

/* File: testbench/chaq_host_model.sv */
/*
 * Host side model that issues single-byte register accesses.
 * Assumes the device samples strobes on the rising edge of clk.
 */
`timescale 1ns/10ps
module chaq_host_model (
	input wire logic clk,
	input wire logic [7:0] reg_rdata,
	output chaq_pkg::chaq_reg_req_t reg_req
);
	initial reg_req = '0;

	// A released bus shows inverted values so stale fields never match.
	task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_req <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		reg_req <= '{1'b0, 1'b0, ~a, ~d};
	endtask

	task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		reg_req <= '{1'b0, 1'b0, ~a, 8'hFF};
		#1 d = reg_rdata;
	endtask
endmodule
